// ==== logic/mrsb_pkg.sv ====
/*
 Package for the Modbus RTU slave buffer bridge: function codes, buffer sizes,
 CRC constants and field widths. Assumes nothing of its surroundings.
*/
package mrsb_pkg;
  localparam int BUF_BYTES = 1024;
  localparam int ADDR_W = 10;
  localparam logic [7:0] FC_READ_COILS = 8'h01;
  localparam logic [7:0] FC_READ_DISC = 8'h02;
  localparam logic [7:0] FC_READ_HOLD = 8'h03;
  localparam logic [7:0] FC_READ_INPUT = 8'h04;
  localparam logic [7:0] FC_WRITE_COIL = 8'h05;
  localparam logic [7:0] FC_WRITE_REG = 8'h06;
  localparam logic [7:0] FC_WRITE_COILS = 8'h0F;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam logic [15:0] COIL_ON = 16'hFF00;
  localparam int REQ_FIXED = 8;
  localparam int REQ_MAX = 64;
  localparam int RSP_MAX = 256;
  localparam logic [3:0] SWITCH_RADIX = 4'hA;
  typedef logic [ADDR_W-1:0] mrsb_addr_t;
  typedef logic [7:0] mrsb_byte_t;
endpackage

// ==== logic/mrsb_crc16.sv ====
/*
 Byte-wise Modbus CRC-16 update step.
 Assumes the caller holds the running value and seeds it with CRC_INIT.
*/
`timescale 1ns/1ps
module mrsb_crc16 (
  input wire logic [15:0] crcIn,
  input wire logic [7:0] dataIn,
  output logic [15:0] crcOut
);
  import mrsb_pkg::*;
  always_comb begin
    crcOut = crcIn ^ {8'h00, dataIn};
    for (int i = 0; i < 8; i++) begin
      if (crcOut[0]) begin
        crcOut = (crcOut >> 1) ^ CRC_POLY;
      end else begin
        crcOut = crcOut >> 1;
      end
    end
  end
endmodule // mrsb_crc16

// ==== logic/mrsb_bridge.sv ====
/*
 Modbus RTU slave engine mapping fieldbus process data onto coils and registers.
 Assumes byte streams already framed (UART and inter-frame gap handled outside);
 reqEnd marks the end of a serial request frame.
*/
`timescale 1ns/1ps
module mrsb_bridge (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic triggerMode,
  input wire logic lengthByteOn,
  input wire logic [3:0] slave_id_high_switch,
  input wire logic [3:0] slave_id_low_switch,
  input wire logic fbInValid,
  input wire mrsb_pkg::mrsb_byte_t fbInData,
  input wire logic fbInLast,
  input wire logic rxValid,
  input wire mrsb_pkg::mrsb_byte_t rxData,
  input wire logic reqEnd,
  input wire logic txReady,
  output logic txValid,
  output mrsb_pkg::mrsb_byte_t txData,
  output logic fbOutValid,
  output mrsb_pkg::mrsb_byte_t fbOutData,
  output logic fbOutLast
);
  import mrsb_pkg::*;

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  mrsb_byte_t fromCtl [BUF_BYTES];
  mrsb_byte_t toCtl [BUF_BYTES];
  mrsb_byte_t req [REQ_MAX];
  mrsb_byte_t rsp [RSP_MAX];
  logic [10:0] toLen_reg;

  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_EXEC = 5'b00010,
    S_SEND = 5'b00100,
    S_FBOUT = 5'b01000,
    S_DROP = 5'b10000
  } mrsb_state_e;
  mrsb_state_e state_reg;

  function automatic mrsb_addr_t wrapAddr(input logic [15:0] a);
    wrapAddr = a[ADDR_W-1:0];
  endfunction

  // ---------------------------------------------------------------
  // fieldbus input side
  // ---------------------------------------------------------------
  logic [10:0] fbPos_reg;
  logic [10:0] fbCount_reg;
  logic [10:0] fbIdx_reg;
  wire logic ctlSlot = triggerMode && fbPos_reg == 11'h000;
  wire logic lenSlot = lengthByteOn && fbPos_reg == {10'h000, triggerMode};
  wire logic payload = !ctlSlot && !lenSlot;
  wire logic storeOk = payload && (!lengthByteOn || fbIdx_reg < fbCount_reg)
    && fbIdx_reg < 11'(BUF_BYTES);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      fbPos_reg <= 11'h000;
      fbIdx_reg <= 11'h000;
      fbCount_reg <= 11'h000;
    end else if (fbInValid) begin
      fbPos_reg <= fbInLast ? 11'h000 : fbPos_reg + 11'h001;
      if (lenSlot) begin
        fbCount_reg <= {3'h0, fbInData};
      end
      if (fbInLast) begin
        fbIdx_reg <= 11'h000;
      end else if (payload) begin
        fbIdx_reg <= fbIdx_reg + 11'h001;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      for (int i = 0; i < BUF_BYTES; i++) begin
        fromCtl[i] <= 8'h00;
      end
    end else if (fbInValid && storeOk) begin
      fromCtl[fbIdx_reg[ADDR_W-1:0]] <= fbInData;
    end
  end

  // ---------------------------------------------------------------
  // serial request capture and check
  // ---------------------------------------------------------------
  logic [6:0] rqLen_reg;
  logic [15:0] rxCrc_reg;
  logic [15:0] rxCrcNext;
  mrsb_crc16 uRxCrc (.crcIn(rxCrc_reg), .dataIn(rxData), .crcOut(rxCrcNext));

  // widen before the product so ids above 15 do not wrap
  wire logic [7:0] myId = 8'(slave_id_high_switch) * 8'(SWITCH_RADIX)
    + {4'h0, slave_id_low_switch};
  wire logic [7:0] fc = req[1];
  wire logic [15:0] rqAddr = {req[2], req[3]};
  wire logic [15:0] rqQty = {req[4], req[5]};
  wire logic reqGood = rxCrc_reg == 16'h0000 && req[0] == myId && rqLen_reg >= 7'(REQ_FIXED);

  always_ff @(posedge clk_sys) begin
    // frame and crc residue stay put until the execute step has judged them
    if (!rst_n || (state_reg != S_IDLE && state_reg != S_EXEC)) begin
      rqLen_reg <= 7'h00;
      rxCrc_reg <= CRC_INIT;
    end else if (state_reg == S_IDLE && !reqEnd && rxValid && rqLen_reg < 7'(REQ_MAX)) begin
      req[rqLen_reg[5:0]] <= rxData;
      rqLen_reg <= rqLen_reg + 7'h01;
      rxCrc_reg <= rxCrcNext;
    end
  end

  // ---------------------------------------------------------------
  // command execution
  // ---------------------------------------------------------------
  wire mrsb_addr_t coilByte = wrapAddr({3'h0, rqAddr[15:3]});
  wire logic [8:0] coilBytes = 9'((rqQty + 16'h0007) >> 3);
  wire logic [8:0] regBytes = 9'(rqQty << 1);
  wire mrsb_addr_t regByte = wrapAddr(rqAddr << 1);
  wire logic isRead = fc == FC_READ_COILS || fc == FC_READ_DISC ||
    fc == FC_READ_HOLD || fc == FC_READ_INPUT;
  wire logic [8:0] dataBytes = (fc == FC_READ_HOLD || fc == FC_READ_INPUT) ? regBytes : coilBytes;
  wire logic [8:0] rspLen = isRead ? dataBytes + 9'd3 : 9'd6;

  function automatic mrsb_byte_t readByte(input logic useTo, input mrsb_addr_t a);
    readByte = useTo ? toCtl[a] : fromCtl[a];
  endfunction

  logic [8:0] txPos_reg;
  logic [8:0] txLen_reg;
  logic [15:0] txCrc_reg;
  logic [15:0] txCrcNext;
  logic [10:0] outPos_reg;
  mrsb_crc16 uTxCrc (.crcIn(txCrc_reg), .dataIn(rsp[txPos_reg[7:0]]), .crcOut(txCrcNext));
  wire logic txBody = txPos_reg < txLen_reg;
  wire logic txHs = txValid && txReady;
  wire logic txLoad = !txValid || txHs;
  wire logic txMore = txPos_reg <= txLen_reg + 9'h001;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_reg <= S_IDLE;
      txLen_reg <= 9'h000;
    end else begin
      unique case (state_reg)
        S_IDLE: begin
          if (reqEnd) begin
            state_reg <= S_EXEC;
          end
        end
        S_EXEC: begin
          state_reg <= reqGood ? S_SEND : S_DROP;
          txLen_reg <= rspLen;
        end
        S_SEND: begin
          // the last handshake takes the crc high byte
          if (txHs && txPos_reg == txLen_reg + 9'h002) begin
            state_reg <= (fc == FC_WRITE_COIL || fc == FC_WRITE_REG || fc == FC_WRITE_COILS)
              ? S_FBOUT : S_IDLE;
          end
        end
        S_FBOUT: begin
          if (fbOutValid && outPos_reg == toLen_reg) begin
            state_reg <= S_IDLE;
          end
        end
        S_DROP: state_reg <= S_IDLE;
      endcase
    end
  end

  // response image and buffer writes
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      for (int i = 0; i < BUF_BYTES; i++) begin
        toCtl[i] <= 8'h00;
      end
      toLen_reg <= 11'h000;
    end else if (state_reg == S_EXEC && reqGood) begin
      rsp[0] <= req[0];
      rsp[1] <= fc;
      if (isRead) begin
        rsp[2] <= dataBytes[7:0];
        for (int i = 0; i < RSP_MAX - 3; i++) begin
          if (fc == FC_READ_HOLD) begin
            rsp[i+3] <= readByte(1'b1, regByte + mrsb_addr_t'(i));
          end else if (fc == FC_READ_INPUT) begin
            rsp[i+3] <= readByte(1'b0, regByte + mrsb_addr_t'(i));
          end else begin
            rsp[i+3] <= readByte(1'b1, coilByte + mrsb_addr_t'(i));
          end
        end
      end else begin
        for (int i = 2; i < 6; i++) begin
          rsp[i] <= req[i];
        end
        if (fc == FC_WRITE_COIL) begin
          toCtl[coilByte][rqAddr[2:0]] <= {req[4], req[5]} == COIL_ON;
          if ({1'b0, coilByte} >= toLen_reg) begin
            toLen_reg <= {1'b0, coilByte} + 11'h001;
          end
        end else if (fc == FC_WRITE_REG) begin
          toCtl[regByte] <= req[4];
          toCtl[regByte + mrsb_addr_t'(1)] <= req[5];
          if ({1'b0, regByte} + 11'h002 > toLen_reg) begin
            toLen_reg <= {1'b0, regByte} + 11'h002;
          end
        end else if (fc == FC_WRITE_COILS) begin
          // start offset is a byte boundary by the master's contract
          for (int i = 0; i < REQ_MAX - 7; i++) begin
            if (i < int'(req[6]) && coilByte + mrsb_addr_t'(i) < mrsb_addr_t'(BUF_BYTES - 1)) begin
              toCtl[coilByte + mrsb_addr_t'(i)] <= req[7+i];
            end
          end
          if ({1'b0, coilByte} + {3'h0, req[6]} > toLen_reg) begin
            toLen_reg <= {1'b0, coilByte} + {3'h0, req[6]};
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // serial transmit with CRC appended low byte first
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n || state_reg != S_SEND) begin
      txPos_reg <= 9'h000;
      txCrc_reg <= CRC_INIT;
      txValid <= 1'b0;
      txData <= 8'h00;
    end else begin
      if (txLoad) begin
        txValid <= txMore;
        if (txBody) begin
          txData <= rsp[txPos_reg[7:0]];
          txCrc_reg <= txCrcNext;
        end else if (txPos_reg == txLen_reg) begin
          txData <= txCrc_reg[7:0];
        end else begin
          txData <= txCrc_reg[15:8];
        end
        if (txMore) begin
          txPos_reg <= txPos_reg + 9'h001;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // fieldbus output: length byte then payload
  // ---------------------------------------------------------------
  wire logic [10:0] outLen = toLen_reg;
  always_ff @(posedge clk_sys) begin
    if (!rst_n || state_reg != S_FBOUT) begin
      outPos_reg <= 11'h000;
      fbOutValid <= 1'b0;
      fbOutData <= 8'h00;
      fbOutLast <= 1'b0;
    end else if (!(fbOutValid && outPos_reg == outLen)) begin
      fbOutValid <= 1'b1;
      fbOutData <= fbOutValid ? toCtl[outPos_reg[ADDR_W-1:0]] : outLen[7:0];
      fbOutLast <= fbOutValid ? outPos_reg + 11'h001 == outLen : outLen == 11'h000;
      if (fbOutValid) begin
        outPos_reg <= outPos_reg + 11'h001;
      end
    end else begin
      fbOutValid <= 1'b0;
      fbOutLast <= 1'b0;
    end
  end
endmodule // mrsb_bridge

// ==== dv/mrsb_modbus_master.sv ====
/*
 Serial Modbus master model facing the bridge request and response streams.
 Assumes one clock; response bytes are collected in rsp for the bench.
*/
`timescale 1ns/1ps
module mrsb_modbus_master (
  input wire logic clk_sys,
  input wire logic txValid,
  input wire mrsb_pkg::mrsb_byte_t txData,
  output logic rxValid,
  output mrsb_pkg::mrsb_byte_t rxData,
  output logic reqEnd,
  output logic txReady
);
  import mrsb_pkg::*;
  mrsb_byte_t rsp[$];
  initial {rxValid, rxData, reqEnd, txReady} = '0;
  // ----------------------------------------
  // requests, crc and stalling response sink
  // ----------------------------------------
  function automatic logic [15:0] crcOf(input mrsb_byte_t b[$]);
    logic [15:0] c;
    c = CRC_INIT;
    foreach (b[i]) begin
      c = c ^ {8'h00, b[i]};
      for (int k = 0; k < 8; k++)
        c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
    end
    return c;
  endfunction
  task automatic sendFrame(input mrsb_byte_t b[$], input logic bad);
    logic [15:0] c;
    c = crcOf(b) ^ {15'h0000, bad};
    b.push_back(c[7:0]);
    b.push_back(c[15:8]);
    foreach (b[i]) begin
      @(posedge clk_sys);
      rxValid <= 1'b1;
      rxData <= b[i];
      @(posedge clk_sys);
      rxValid <= 1'b0;
      rxData <= ~b[i];
    end
    @(posedge clk_sys);
    reqEnd <= 1'b1;
    @(posedge clk_sys);
    reqEnd <= 1'b0;
  endtask
  always @(posedge clk_sys) begin
    if (txValid && txReady) rsp.push_back(txData);
    txReady <= ($urandom_range(3) != 0);
  end
endmodule // mrsb_modbus_master

// ==== dv/mrsb_bridge_properties.sv ====
/*
 Port-level checks on the bridge streams.
 Assumes the bind below attaches it to each mrsb_bridge instance.
*/
`timescale 1ns/1ps
module mrsb_bridge_properties (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic reqEnd,
  input wire logic txReady,
  input wire logic txValid,
  input wire mrsb_pkg::mrsb_byte_t txData,
  input wire logic fbOutValid,
  input wire mrsb_pkg::mrsb_byte_t fbOutData,
  input wire logic fbOutLast
);
  import mrsb_pkg::*;
  logic inFrame;
  logic [8:0] fbCnt;
  mrsb_byte_t fbLen;
  logic [11:0] sinceReq;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // helpers and assertions
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n || reqEnd) sinceReq <= 12'h000;
    else if (sinceReq != 12'hFFF) sinceReq <= sinceReq + 12'h001;
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) inFrame <= 1'b0;
    else if (fbOutValid) inFrame <= !fbOutLast;
    if (fbOutValid && !inFrame) fbLen <= fbOutData;
    fbCnt <= (fbOutValid && !inFrame) ? 9'h000 : fbCnt + {8'h00, fbOutValid};
  end
  a_tx_hold: assert property (txValid && !txReady |=> txValid && $stable(txData))
    else $error("tx byte changed before it was taken");
  a_fb_count: assert property (fbOutValid && fbOutLast && inFrame |-> fbCnt + 9'h001 == {1'b0, fbLen})
    else $error("fieldbus output length byte disagrees with payload count");
  a_fb_first_len: assert property (fbOutValid && !inFrame |-> (fbOutData == 8'h00) == fbOutLast)
    else $error("fieldbus output length byte disagrees with frame end");
  a_fb_after_resp: assert property ($rose(fbOutValid) |-> !txValid)
    else $error("fieldbus output started during response");
  a_fb_near_req: assert property (fbOutValid |-> sinceReq < 12'h800)
    else $error("fieldbus output without recent serial request");
  a_tx_after_req: assert property (txValid |-> sinceReq < 12'h800)
    else $error("response without recent request");
  a_tx_req_idle: assert property (reqEnd |-> !txValid ##1 !txValid)
    else $error("response began before request executed");
  a_reset_quiet: assert property ($rose(rst_n) |-> !txValid && !fbOutValid && !fbOutLast)
    else $error("outputs active right after reset");
  c_fb_frame: cover property (fbOutValid && fbOutLast && inFrame);
  c_tx_stall: cover property (txValid && !txReady);
  c_req_end: cover property (reqEnd);
endmodule // mrsb_bridge_properties
bind mrsb_bridge mrsb_bridge_properties i_mrsb_bridge_properties (.*);

// ==== dv/mrsb_bridge_tb.sv ====
/*
 Self-checking bench for the bridge with a serial master model.
 Assumes the checker is bound from its own file.
*/
`timescale 1ns/1ps
module mrsb_bridge_tb;
  import mrsb_pkg::*;
  localparam mrsb_byte_t ID = 8'h0C;
  logic clk_sys, rst_n, triggerMode, lengthByteOn, fbInValid, fbInLast;
  logic rxValid, reqEnd, txReady, txValid, fbOutValid, fbOutLast;
  logic [3:0] slave_id_high_switch, slave_id_low_switch;
  mrsb_byte_t fbInData, rxData, txData, fbOutData;
  mrsb_byte_t fromB[1024], toB[1024], fbq[$], q[$], e[$];
  int num_errors, checks, hiW, lastAt;
  mrsb_bridge i_mrsb_bridge (.*);
  mrsb_modbus_master i_mrsb_modbus_master (.*);
  // ----------------------------------------
  // clock, tasks and test sequence
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (fbOutValid) begin
      fbq.push_back(fbOutData);
      if (fbOutLast) lastAt = fbq.size();
    end
  end
  task automatic cmp(input mrsb_byte_t got, input mrsb_byte_t exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic fbSend(input logic ctrl, input int len, input int n);
    mrsb_byte_t b;
    triggerMode <= ctrl;
    for (int i = -1 - int'(ctrl); i < n; i++) begin
      b = (i == -1) ? len[7:0] : 8'($urandom);
      if (i >= 0 && i < len) fromB[i] = b;
      fbInValid <= 1'b1;
      fbInData <= b;
      fbInLast <= (i == n - 1);
      @(posedge clk_sys);
    end
    fbInValid <= 1'b0;
  endtask
  task automatic addCrc();
    logic [15:0] c;
    c = i_mrsb_modbus_master.crcOf(e);
    e.push_back(c[7:0]);
    e.push_back(c[15:8]);
  endtask
  task automatic run(input logic bad, input logic wr);
    i_mrsb_modbus_master.rsp.delete();
    i_mrsb_modbus_master.sendFrame(q, bad);
    for (int t = 0; t < 3000 && i_mrsb_modbus_master.rsp.size() < e.size(); t++)
      @(posedge clk_sys);
    repeat (300) @(posedge clk_sys);
    cmp(8'(i_mrsb_modbus_master.rsp.size()), 8'(e.size()));
    foreach (e[i]) cmp(i_mrsb_modbus_master.rsp[i], e[i]);
    e.delete();
    if (wr) e = {8'(hiW)};
    for (int i = 0; wr && i < hiW; i++) e.push_back(toB[i]);
    cmp(8'(fbq.size()), 8'(e.size()));
    foreach (e[i]) cmp(fbq[i], e[i]);
    cmp(8'(lastAt), 8'(e.size()));
    fbq.delete();
    lastAt = 0;
  endtask
  task automatic rd(input mrsb_byte_t fc, input int start, input int qty);
    int n, base;
    n = (fc < FC_READ_HOLD) ? qty / 8 : 2 * qty;
    base = (fc < FC_READ_HOLD) ? start / 8 : 2 * start;
    q = {ID, fc, 8'(start >> 8), 8'(start), 8'(qty >> 8), 8'(qty)};
    e = {ID, fc, 8'(n)};
    for (int i = 0; i < n; i++)
      e.push_back(fc == FC_READ_INPUT ? fromB[base + i] : toB[base + i]);
    addCrc();
    run(1'b0, 1'b0);
  endtask
  task automatic wr(input mrsb_byte_t fc, input int adr, input logic [15:0] v);
    q = {ID, fc, 8'(adr >> 8), 8'(adr), v[15:8], v[7:0]};
    e = q;
    if (fc == FC_WRITE_REG) begin
      toB[2 * adr] = v[15:8];
      toB[2 * adr + 1] = v[7:0];
      hiW = (2 * adr + 2 > hiW) ? 2 * adr + 2 : hiW;
    end else begin
      toB[adr / 8][adr % 8] = (v == COIL_ON);
      hiW = (adr / 8 + 1 > hiW) ? adr / 8 + 1 : hiW;
    end
    addCrc();
    run(1'b0, 1'b1);
  endtask
  initial begin
    #400000;
    num_errors++;
    give_verdict();
  end
  initial begin
    void'($urandom(6599));
    {rst_n, triggerMode, lengthByteOn, fbInValid, fbInData, fbInLast} = '0;
    slave_id_high_switch = 4'h1;
    slave_id_low_switch = 4'h2;
    toB = '{default: 8'h00};
    fromB = '{default: 8'h00};
    hiW = 0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    lengthByteOn <= 1'b1;
    fbSend(1'b1, 48, 60);
    rd(FC_READ_INPUT, 0, 30);
    fbSend(1'b0, 7, 20);
    rd(FC_READ_INPUT, 0, 8);
    rd(FC_READ_HOLD, 0, 4);
    wr(FC_WRITE_REG, $urandom_range(31), 16'($urandom));
    wr(FC_WRITE_COIL, 1, COIL_ON);
    rd(FC_READ_COILS, 0, 16);
    rd(FC_READ_HOLD, 0, 32);
    q = {ID, FC_WRITE_COILS, 8'h00, 8'h00, 8'h00, 8'h08, 8'h01, 8'h0E};
    e = q[0:5];
    toB[0] = 8'h0E;
    addCrc();
    run(1'b0, 1'b1);
    rd(FC_READ_COILS, 5, 8);
    for (int k = 0; k < 2; k++) begin
      q = {k ? ID + 8'h01 : ID, FC_READ_HOLD, 8'h00, 8'h00, 8'h00, 8'h01};
      e.delete();
      run(k == 0, 1'b0);
    end
    give_verdict();
  end
endmodule // mrsb_bridge_tb
